// *** rtl/unbalance_pkg.sv ***
// Purpose: Shared constants and carriers of the neutral unbalance stage.
// Assumes: One program cycle tick of 5 ms from the relay timebase.
// Notes: Times count in 5 ms steps; current in 0.01 A steps.
package unbalance_pkg;
  // ****************************************************************
  // Timing and scaling
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_MS = 5;
  localparam int BLOCK_LEAD_MS = 5;
  localparam int BLOCK_LEAD_TICKS = (BLOCK_LEAD_MS + TICK_MS - 1) / TICK_MS;
  localparam int MAX_TRIP_S = 1800;
  localparam logic [18:0] MAX_TRIP_TICKS = 19'(MAX_TRIP_S * 1000 / TICK_MS);
  localparam int RESET_RATIO_PCT = 97;
  localparam int PCT_FULL = 100;
  localparam int LOG_DEPTH = 12;
  localparam int EVT_COUNT = 14;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] HARM_DEFAULT = 16'h0001;
  // ****************************************************************
  // Encodings
  // ****************************************************************
  localparam logic [1:0] COND_NORMAL = 2'h0;
  localparam logic [1:0] COND_START = 2'h1;
  localparam logic [1:0] COND_TRIP = 2'h2;
  localparam logic [1:0] COND_BLOCKED = 2'h3;
  localparam logic [2:0] BEH_ON = 3'h0;
  localparam logic [2:0] BEH_BLOCKED = 3'h1;
  localparam logic [2:0] BEH_TEST = 3'h2;
  localparam logic [2:0] BEH_TEST_BLOCKED = 3'h3;
  localparam logic [2:0] BEH_OFF = 3'h4;
  localparam logic [1:0] LOG_EV_START = 2'h0;
  localparam logic [1:0] LOG_EV_TRIP = 2'h1;
  localparam logic [1:0] LOG_EV_BLOCKED = 2'h2;
  // Event codes: code*2 is ON, code*2+1 is OFF.
  localparam int EV_ALARM_START = 0;
  localparam int EV_ALARM = 1;
  localparam int EV_START = 2;
  localparam int EV_TRIP = 3;
  localparam int EV_BANK_A = 4;
  localparam int EV_BANK_B = 5;
  localparam int EV_COMP = 6;
  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [15:0] current;
    logic [15:0] angle;
    logic [7:0] fuses_a;
    logic [7:0] fuses_b;
    logic side_b;
    logic [2:0] group;
  } process_t;
  typedef struct packed {
    logic [47:0] stamp_ms;
    logic [1:0] event_code;
    process_t data;
    logic [18:0] trip_left;
  } log_rec_t;
  typedef struct packed {
    logic [47:0] stamp_ms;
    logic [3:0] code;
  } event_t;
endpackage

// *** rtl/neutral_unbalance_stage.sv ***
// Purpose: Status, blocking, event and log logic of one unbalance stage.
// Assumes: Pick-up levels arrive from the comparator on the same clock.
// Notes: Status, alarm and timer state advance on the program cycle tick only; events, counters and log update every clock.
`timescale 1ns/1ps
module neutral_unbalance_stage #(
  parameter int DEPTH = unbalance_pkg::LOG_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Timebase and measurement
  input wire logic tick_i,
  input wire logic [47:0] time_ms_i,
  input wire unbalance_pkg::process_t meas_i,
  input wire logic [15:0] harm_ratio_i,
  input wire logic comp_active_i,
  // Settings
  input wire logic [15:0] alarm_set_i,
  input wire logic [15:0] trip_set_i,
  input wire logic [18:0] alarm_delay_i,
  input wire logic [18:0] trip_delay_i,
  input wire logic inrush_en_i,
  input wire logic [15:0] harm_limit_i,
  input wire logic [2:0] mode_i,
  input wire logic [13:0] evt_on_en_i,
  input wire logic [13:0] evt_off_en_i,
  input wire logic counters_clear_i,
  // Blocking pin
  input wire logic block_i,
  // Status outputs
  output logic start_o,
  output logic alarm_start_o,
  output logic alarm_o,
  output logic trip_o,
  output logic blocked_o,
  output logic [1:0] condition_o,
  output logic [2:0] behaviour_o,
  output logic [18:0] trip_left_o,
  output logic [18:0] alarm_expect_o,
  output logic [15:0] ratio_o,
  output logic [15:0] current_o,
  output logic [15:0] angle_o,
  // Events and counters
  output logic event_valid_o,
  output unbalance_pkg::event_t event_o,
  output logic [15:0] cnt_alarm_start_o,
  output logic [15:0] cnt_alarm_o,
  output logic [15:0] cnt_start_o,
  output logic [15:0] cnt_trip_o,
  output logic [15:0] cnt_blocked_o,
  // Log read
  input wire logic [3:0] log_sel_i,
  output unbalance_pkg::log_rec_t log_rec_o,
  output logic [3:0] log_count_o
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic pick(input logic [15:0] m, input logic [15:0] s,
                                input logic held);
    logic [31:0] lhs;
    logic [31:0] rhs;
    lhs = {16'h0000, m} * 32'(unbalance_pkg::PCT_FULL);
    rhs = {16'h0000, s} * 32'(unbalance_pkg::RESET_RATIO_PCT);
    pick = held ? (lhs >= rhs) : (m > s);
  endfunction

  function automatic logic [15:0] bump(input logic [15:0] c, input logic e,
                                       input logic clr);
    bump = clr ? 16'h0000 : (e ? c + unbalance_pkg::CNT_ONE : c);
  endfunction

  // Maps a read selection, newest first, onto a log slot.
  function automatic logic [3:0] slot(input logic [3:0] w,
                                      input logic [3:0] s);
    logic [4:0] t;
    t = 5'(w) + 5'(DEPTH) - 5'h01 - 5'(s);
    slot = (t >= 5'(DEPTH)) ? 4'(t - 5'(DEPTH)) : 4'(t);
  endfunction

  // ****************************************************************
  // Blocking synchroniser
  // ****************************************************************
  logic block_s1;
  logic block_s2;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      block_s1 <= 1'b0;
      block_s2 <= 1'b0;
    end else begin
      block_s1 <= block_i;
      block_s2 <= block_s1;
    end
  end

  // ****************************************************************
  // Stage state
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_NORMAL = 4'h1,
    ST_START = 4'h2,
    ST_TRIP = 4'h4,
    ST_BLOCKED = 4'h8
  } stage_t;
  stage_t state, next_state;
  logic alarm_pick, next_alarm_pick;
  logic alarm, next_alarm;
  logic [18:0] alarm_cnt, next_alarm_cnt;
  logic [18:0] trip_cnt, next_trip_cnt;
  logic blk;
  logic inhibit;
  logic off;
  logic trip_pick;
  logic inrush;

  // Blocking is read only from the synchroniser at the tick.
  assign blk = block_s2;
  assign off = (mode_i == unbalance_pkg::BEH_OFF);
  assign inhibit = blk || mode_i == unbalance_pkg::BEH_BLOCKED ||
                   mode_i == unbalance_pkg::BEH_TEST_BLOCKED;
  assign inrush = inrush_en_i &&
                  (harm_ratio_i >= harm_limit_i);
  assign trip_pick = pick(meas_i.current, trip_set_i, state != ST_NORMAL &&
                          state != ST_BLOCKED);

  always_comb begin
    next_state = state;
    next_alarm_pick = alarm_pick;
    next_alarm = alarm;
    next_alarm_cnt = alarm_cnt;
    next_trip_cnt = trip_cnt;
    if (tick_i) begin
      next_alarm_pick = !off && !inhibit &&
                        pick(meas_i.current, alarm_set_i, alarm_pick);
      next_alarm_cnt = next_alarm_pick ? alarm_cnt + 19'h00001 :
                       19'h00000;
      // Alarm counts only the ticks already spent picked up; trip also counts the current tick.
      next_alarm = next_alarm_pick && alarm_cnt >= alarm_delay_i;
      case (state)
        ST_NORMAL: begin
          next_trip_cnt = 19'h00000;
          if (!off && trip_pick) begin
            next_state = inhibit ? ST_BLOCKED : ST_START;
          end
        end
        ST_START: begin
          if (off || !trip_pick) begin
            next_state = ST_NORMAL;
          end else if (inhibit) begin
            next_state = ST_BLOCKED;
            next_trip_cnt = 19'h00000;
          end else if (trip_cnt + 19'h00001 >= trip_delay_i && !inrush) begin
            next_state = ST_TRIP;
            next_trip_cnt = trip_cnt + 19'h00001;
          end else if (trip_cnt < unbalance_pkg::MAX_TRIP_TICKS) begin
            next_trip_cnt = trip_cnt + 19'h00001;
          end
        end
        ST_TRIP: begin
          if (off || !trip_pick || inhibit) begin
            next_state = ST_NORMAL;
          end
        end
        ST_BLOCKED: begin
          if (off || !trip_pick || !inhibit) begin
            next_state = ST_NORMAL;
          end
        end
        default: next_state = ST_NORMAL;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= ST_NORMAL;
      alarm_pick <= 1'b0;
      alarm <= 1'b0;
      alarm_cnt <= 19'h00000;
      trip_cnt <= 19'h00000;
    end else begin
      state <= next_state;
      alarm_pick <= next_alarm_pick;
      alarm <= next_alarm;
      alarm_cnt <= next_alarm_cnt;
      trip_cnt <= next_trip_cnt;
    end
  end

  // ****************************************************************
  // Published values
  // ****************************************************************
  always_comb begin
    start_o = (state == ST_START) || (state == ST_TRIP);
    trip_o = (state == ST_TRIP);
    blocked_o = (state == ST_BLOCKED);
    alarm_start_o = alarm_pick;
    alarm_o = alarm;
    case (state)
      ST_START: condition_o = unbalance_pkg::COND_START;
      ST_TRIP: condition_o = unbalance_pkg::COND_TRIP;
      ST_BLOCKED: condition_o = unbalance_pkg::COND_BLOCKED;
      default: condition_o = unbalance_pkg::COND_NORMAL;
    endcase
    behaviour_o = mode_i;
    trip_left_o = (state == ST_START && trip_delay_i > trip_cnt) ?
                  trip_delay_i - trip_cnt : 19'h00000;
    alarm_expect_o = alarm_delay_i;
    ratio_o = (alarm_set_i == 16'h0000) ? 16'hffff :
              16'((32'(meas_i.current) * 32'(unbalance_pkg::PCT_FULL)) /
                  32'(alarm_set_i));
    current_o = meas_i.current;
    angle_o = meas_i.angle;
  end

  // ****************************************************************
  // Events and counters
  // ****************************************************************
  logic [6:0] prev, now_lv;
  logic [13:0] pend, next_pend;
  logic ev_v, next_ev_v;
  unbalance_pkg::event_t ev, next_ev;
  logic [15:0] c_as, c_al, c_st, c_tr, c_bl;
  logic blk_prev;
  assign now_lv = {comp_active_i, meas_i.side_b, !meas_i.side_b && start_o,
                   trip_o, start_o, alarm_o, alarm_start_o};

  always_comb begin
    next_pend = pend;
    next_ev_v = 1'b0;
    next_ev = ev;
    for (int j = unbalance_pkg::EVT_COUNT - 1; j >= 0; j--) begin
      if (pend[j]) begin
        next_ev_v = 1'b1;
        next_ev.code = 4'(j);
        next_ev.stamp_ms = time_ms_i;
      end
    end
    for (int j = 0; j < unbalance_pkg::EVT_COUNT; j++) begin
      if (pend[j] && next_ev.code == 4'(j)) next_pend[j] = 1'b0;
    end
    // New edges set their bits after the clear, so none is lost.
    for (int i = 0; i < unbalance_pkg::EVT_COUNT / 2; i++) begin
      if (now_lv[i] && !prev[i] && evt_on_en_i[2*i]) begin
        next_pend[2*i] = 1'b1;
      end
      if (!now_lv[i] && prev[i] && evt_off_en_i[2*i+1]) begin
        next_pend[2*i+1] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      prev <= 7'h00;
      pend <= 14'h0000;
      ev_v <= 1'b0;
      ev <= '0;
      c_as <= 16'h0000;
      c_al <= 16'h0000;
      c_st <= 16'h0000;
      c_tr <= 16'h0000;
      c_bl <= 16'h0000;
    end else begin
      prev <= now_lv;
      pend <= next_pend;
      ev_v <= next_ev_v;
      ev <= next_ev;
      c_as <= bump(c_as, now_lv[0] && !prev[0], counters_clear_i);
      c_al <= bump(c_al, now_lv[1] && !prev[1], counters_clear_i);
      c_st <= bump(c_st, now_lv[2] && !prev[2], counters_clear_i);
      c_tr <= bump(c_tr, now_lv[3] && !prev[3], counters_clear_i);
      c_bl <= bump(c_bl, blocked_o && !blk_prev, counters_clear_i);
    end
  end
  assign event_valid_o = ev_v;
  assign event_o = ev;
  assign cnt_alarm_start_o = c_as;
  assign cnt_alarm_o = c_al;
  assign cnt_start_o = c_st;
  assign cnt_trip_o = c_tr;
  assign cnt_blocked_o = c_bl;

  // ****************************************************************
  // Operation log
  // ****************************************************************
  unbalance_pkg::log_rec_t mem [DEPTH];
  logic [3:0] wr, next_wr;
  logic [3:0] cnt, next_cnt;
  logic cap;
  unbalance_pkg::log_rec_t rec;
  assign cap = (start_o && !prev[2]) || (trip_o && !prev[3]) ||
               (blocked_o && !blk_prev);

  always_comb begin
    rec.stamp_ms = time_ms_i;
    rec.event_code = trip_o ? unbalance_pkg::LOG_EV_TRIP :
                     blocked_o ? unbalance_pkg::LOG_EV_BLOCKED :
                     unbalance_pkg::LOG_EV_START;
    rec.data = meas_i;
    rec.trip_left = trip_left_o;
    next_wr = wr;
    next_cnt = cnt;
    if (cap) begin
      next_wr = (wr == 4'(DEPTH - 1)) ? 4'h0 : wr + 4'h1;
      next_cnt = (cnt == 4'(DEPTH)) ? cnt : cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr <= 4'h0;
      cnt <= 4'h0;
      blk_prev <= 1'b0;
    end else begin
      wr <= next_wr;
      cnt <= next_cnt;
      blk_prev <= blocked_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (cap) mem[wr] <= rec;
  end

  // Selection 0 is the newest record.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) log_rec_o <= '0;
    else if (log_sel_i < cnt) log_rec_o <= mem[slot(wr, log_sel_i)];
    else log_rec_o <= '0;
  end
  assign log_count_o = cnt;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_pick_blocked;
    tick_i && state == ST_NORMAL && trip_pick && inhibit && !off;
  endsequence
  a_block_entry: assert property (@(posedge clk_i) disable iff (reset_i)
    s_pick_blocked |=> blocked_o && !start_o)
    else $error("pick-up while blocked did not raise blocked");
  a_start_entry: assert property (@(posedge clk_i) disable iff (reset_i)
    tick_i && state == ST_NORMAL && trip_pick && !inhibit && !off
    |=> start_o && !trip_o)
    else $error("pick-up did not raise start");
  a_block_clears: assert property (@(posedge clk_i) disable iff (reset_i)
    tick_i && state == ST_START && trip_pick && inhibit && !off
    |=> !start_o && trip_left_o == 19'h00000)
    else $error("blocking did not clear start");
  a_inrush_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    state == ST_START && inrush |=> !trip_o)
    else $error("trip issued during inrush");
  a_log_capacity: assert property (@(posedge clk_i) disable iff (reset_i)
    cnt <= 4'(DEPTH))
    else $error("log count exceeds depth");
  a_log_advance: assert property (@(posedge clk_i) disable iff (reset_i)
    cap && cnt == 4'(DEPTH) |=>
    cnt == 4'(DEPTH) && wr != $past(wr))
    else $error("full log did not overwrite oldest");
  a_count_start: assert property (@(posedge clk_i) disable iff (reset_i)
    start_o && !prev[2] && !counters_clear_i |=>
    c_st == $past(c_st) + 16'h1)
    else $error("start counter missed an occurrence");
  a_event_stamp: assert property (@(posedge clk_i) disable iff (reset_i)
    next_ev_v |=> ev_v && ev.stamp_ms == $past(time_ms_i))
    else $error("event not stamped with current time");
endmodule // neutral_unbalance_stage

// *** verification/block_source.sv ***
// Purpose: Blocking matrix model that drives the stage blocking pin.
// Assumes: Requests arrive as a level; lag counts clock cycles.
// Notes: The pin changes only shortly after a rising clock edge.
`timescale 1ns/1ps
module block_source (
  // Clock
  input wire logic clk_i,
  // Request from the bench
  input wire logic want_i,
  input wire logic [7:0] lag_i,
  // Blocking pin
  output logic block_o
);
  logic [7:0] wait_left;
  logic want;
  logic [7:0] lag;
  initial begin
    block_o = 1'b0;
    wait_left = 8'h00;
    forever begin
      @(posedge clk_i);
      // Requests are taken at the edge, before the bench moves them.
      want = want_i;
      lag = lag_i;
      #1;
      if (want == block_o) begin
        wait_left = lag;
      end else if (wait_left != 8'h00) begin
        wait_left = wait_left - 8'h01;
      end else begin
        block_o = want;
      end
    end
  end
endmodule // block_source

// *** verification/tb_top.sv ***
// Purpose: Self-checking bench of the neutral unbalance stage.
// Assumes: Program cycle ticks are pulsed by the bench.
// Notes: Events are collected in a queue and searched by code.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
  bad_count++; $display("unexpected %s exp %0h got %0h", nm, ex, got); \
  end end
module tb_top;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clk_i, reset_i, tick, comp, inrush, clr, want, blk;
  logic [47:0] time_ms;
  unbalance_pkg::process_t meas;
  logic [15:0] harm, alarm_set, trip_set, harm_lim;
  logic [18:0] alarm_dly, trip_dly;
  logic [2:0] mode;
  logic [13:0] on_en, off_en;
  logic [7:0] lag;
  logic [3:0] sel;
  logic start_o, alarm_start_o, alarm_o, trip_o, blocked_o, event_valid_o;
  logic [1:0] condition_o;
  logic [2:0] behaviour_o;
  logic [18:0] trip_left_o, alarm_expect_o;
  logic [15:0] ratio_o, current_o, angle_o, c_as, c_al, c_st, c_tr, c_bl;
  unbalance_pkg::event_t event_o;
  unbalance_pkg::log_rec_t rec;
  logic [3:0] log_count_o;
  unbalance_pkg::event_t evq[$];
  int bad_count, checked, n;
  // ****************************************************************
  // Instances
  // ****************************************************************
  neutral_unbalance_stage dut (.clk_i(clk_i), .reset_i(reset_i),
    .tick_i(tick), .time_ms_i(time_ms), .meas_i(meas), .harm_ratio_i(harm),
    .comp_active_i(comp), .alarm_set_i(alarm_set), .trip_set_i(trip_set),
    .alarm_delay_i(alarm_dly), .trip_delay_i(trip_dly),
    .inrush_en_i(inrush), .harm_limit_i(harm_lim), .mode_i(mode),
    .evt_on_en_i(on_en), .evt_off_en_i(off_en), .counters_clear_i(clr),
    .block_i(blk), .start_o(start_o), .alarm_start_o(alarm_start_o),
    .alarm_o(alarm_o), .trip_o(trip_o), .blocked_o(blocked_o),
    .condition_o(condition_o), .behaviour_o(behaviour_o),
    .trip_left_o(trip_left_o), .alarm_expect_o(alarm_expect_o),
    .ratio_o(ratio_o), .current_o(current_o), .angle_o(angle_o),
    .event_valid_o(event_valid_o), .event_o(event_o),
    .cnt_alarm_start_o(c_as), .cnt_alarm_o(c_al), .cnt_start_o(c_st),
    .cnt_trip_o(c_tr), .cnt_blocked_o(c_bl), .log_sel_i(sel),
    .log_rec_o(rec), .log_count_o(log_count_o));
  block_source partner (.clk_i(clk_i), .want_i(want), .lag_i(lag),
    .block_o(blk));
  // ****************************************************************
  // Clock and event capture
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (event_valid_o === 1'b1) evq.push_back(event_o);
  end
  function automatic logic [47:0] stamp_of(input logic [3:0] c);
    stamp_of = '1;
    foreach (evq[i]) if (evq[i].code === c) stamp_of = evq[i].stamp_ms;
  endfunction
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task final_report;
    if (bad_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task tk(input logic [15:0] cur);
    @(posedge clk_i) #1;
    meas.current = cur;
    time_ms = time_ms + 48'h5;
    tick = 1'b1;
    @(posedge clk_i) #1;
    tick = 1'b0;
    repeat (16) @(posedge clk_i);
    #1;
  endtask
  task rd(input logic [3:0] s);
    sel = s;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task s_start;
    evq = {};
    tk(16'h00fa);
    `CHK("start", 1'b1, start_o)
    `CHK("cond", unbalance_pkg::COND_START, condition_o)
    `CHK("stamp", time_ms, stamp_of(4'h4))
    `CHK("alm_on", time_ms, stamp_of(4'h0))
    `CHK("bank_a", time_ms, stamp_of(4'h8))
    `CHK("cnt_st", 16'h0001, c_st)
    `CHK("logcnt", 4'h1, log_count_o)
    `CHK("left", trip_dly, trip_left_o)
    rd(4'h0);
    `CHK("log_ev", unbalance_pkg::LOG_EV_START, rec.event_code)
    `CHK("log_cur", 16'h00fa, rec.data.current)
    `CHK("log_grp", 3'h2, rec.data.group)
    `CHK("log_left", trip_dly, rec.trip_left)
    `CHK("log_t", time_ms, rec.stamp_ms)
    `CHK("ratio", 16'h00fa, ratio_o)
    `CHK("cur", 16'h00fa, current_o)
    `CHK("angle", meas.angle, angle_o)
    `CHK("alm_exp", alarm_dly, alarm_expect_o)
  endtask
  task s_hyst;
    tk(16'h00c2);
    `CHK("hold97", 1'b1, start_o)
    evq = {};
    tk(16'h00c1);
    `CHK("drop97", 1'b0, start_o)
    `CHK("st_off", time_ms, stamp_of(4'h5))
    `CHK("off_nolog", 4'h1, log_count_o)
  endtask
  task s_trip;
    tk(16'h00fa);
    n = 0;
    while (trip_o !== 1'b1 && n < 8) begin
      tk(16'h00fa);
      n++;
    end
    if (trip_o !== 1'b1) begin
      bad_count++;
      final_report();
    end
    `CHK("trip_n", int'(trip_dly), n)
    `CHK("cond_tr", unbalance_pkg::COND_TRIP, condition_o)
    `CHK("cnt_tr", 16'h0001, c_tr)
    `CHK("alarm", 1'b1, alarm_o)
    `CHK("cnt_al", 16'h0001, c_al)
    `CHK("cnt_as", 16'h0001, c_as)
    rd(4'h0);
    `CHK("log_tr", unbalance_pkg::LOG_EV_TRIP, rec.event_code)
    tk(16'h0000);
    tk(16'h0000);
  endtask
  task s_block;
    tk(16'h00fa);
    evq = {};
    lag = 8'h02;
    want = 1'b1;
    repeat (8) @(posedge clk_i);
    #1;
    tk(16'h00fa);
    `CHK("blk_st", 1'b0, start_o)
    `CHK("blk", 1'b1, blocked_o)
    `CHK("cond_bl", unbalance_pkg::COND_BLOCKED, condition_o)
    `CHK("blk_off", time_ms, stamp_of(4'h5))
    `CHK("cnt_bl", 16'h0001, c_bl)
    rd(4'h0);
    `CHK("log_bl", unbalance_pkg::LOG_EV_BLOCKED, rec.event_code)
    tk(16'h0000);
    evq = {};
    tk(16'h00fa);
    `CHK("pick_bl", 1'b1, blocked_o)
    `CHK("no_st", '1, stamp_of(4'h4))
    `CHK("cnt_bl2", 16'h0002, c_bl)
    want = 1'b0;
    repeat (8) @(posedge clk_i);
    #1;
    tk(16'h0000);
    `CHK("unblk", 1'b0, blocked_o)
  endtask
  task s_events;
    evq = {};
    on_en[4] = 1'b0;
    tk(16'h00fa);
    `CHK("no_on", '1, stamp_of(4'h4))
    on_en = '1;
    tk(16'h0000);
    comp = 1'b1;
    tk(16'h0000);
    `CHK("comp_on", time_ms, stamp_of(4'hc))
    off_en[13] = 1'b0;
    comp = 1'b0;
    tk(16'h0000);
    `CHK("no_off", '1, stamp_of(4'hd))
    off_en = '1;
  endtask
  task s_log;
    for (int i = 0; i < 13; i++) begin
      tk(16'h00c9 + 16'(i));
      tk(16'h0000);
    end
    `CHK("full", 4'hc, log_count_o)
    rd(4'h0);
    `CHK("newest", 16'h00d5, rec.data.current)
    rd(4'hb);
    `CHK("oldest", 16'h00ca, rec.data.current)
    rd(4'hc);
    `CHK("beyond", '0, rec)
  endtask
  task s_misc;
    clr = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    clr = 1'b0;
    @(posedge clk_i) #1;
    `CHK("clr", 16'h0000, c_st)
    `CHK("clr_all", 16'h0000, c_as | c_al | c_tr | c_bl)
    for (int m = 0; m < 5; m++) begin
      mode = 3'(m);
      repeat (2) @(posedge clk_i);
      #1;
      `CHK("beh", 3'(m), behaviour_o)
    end
    tk(16'h00fa);
    `CHK("off", unbalance_pkg::COND_NORMAL, condition_o)
    mode = unbalance_pkg::BEH_ON;
    inrush = 1'b1;
    harm = 16'h01f4;
    for (int i = 0; i < 8; i++) tk(16'h00fa);
    `CHK("inr_st", 1'b1, start_o)
    `CHK("inr_tr", 1'b0, trip_o)
    harm = 16'h0063;
    tk(16'h00fa);
    `CHK("inr_lim", 1'b1, trip_o)
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    bad_count = 0;
    checked = 0;
    reset_i = 1'b1;
    {tick, comp, inrush, clr, want} = '0;
    time_ms = 48'h0;
    meas = '0;
    meas.angle = 16'h0123;
    meas.group = 3'h2;
    {harm, lag, sel} = '0;
    harm_lim = 16'h0064;
    alarm_set = 16'h0064;
    trip_set = 16'h00c8;
    alarm_dly = 19'h00007;
    trip_dly = 19'h00005;
    mode = unbalance_pkg::BEH_ON;
    on_en = '1;
    off_en = '1;
    repeat (6) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    `CHK("rst_st", 1'b0, start_o)
    `CHK("rst_log", 4'h0, log_count_o)
    s_start();
    s_hyst();
    s_trip();
    s_block();
    s_events();
    s_log();
    s_misc();
    final_report();
  end
endmodule // tb_top
